// >>> src/gcrb_general_config_register_bank.sv
`timescale 1ns/1ps
`include "gcrb_consts.svh"
// Behaviour
// [R1] At start-up fetch every EEPROM-loadable configuration register from the EEPROM.
// [R2] Defaults after start-up; EEPROM values replace them only with a valid CRC.
// [R3] Lockable registers refuse writes while the lock is engaged.
// [R4] A control bit written 1 turns its function on, 0 turns it off.
// [R5] Per-channel registers exist separately for channel one and two, independent.
// [R6] Auto-configured registers are overridden by the device when conditions demand.
// [R7] Unmapped register bits read as zero and ignore writes.
module gcrb_general_config_register_bank (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic ee_req,
    output logic [7:0] ee_addr,
    input wire logic ee_ack,
    input wire logic [7:0] ee_data,
    input wire logic ee_crc_valid,
    input wire logic [7:0] die_temp,
    input wire logic [13:0] diag_result,
    input wire logic [7:0] sec_status_ch1,
    input wire logic [7:0] sec_status_ch2,
    input wire logic [7:0] spv_status,
    input wire logic [7:0] wafer_die_high,
    input wire logic [7:0] die_index_low,
    input wire logic diag_auto_req,
    input wire logic [3:0] diag_auto_ch,
    input wire logic cj_temp_valid,
    input wire logic [15:0] cj_temp_meas,
    output gcrb_pkg::gcrb_cfg_type cfg_out,
    output logic locked,
    output logic soft_reset,
    output logic boot_done,
    output logic irq
);

    gcrb_pkg::gcrb_state_type state_reg;
    gcrb_pkg::gcrb_state_type state_next;

    function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [7:0] new_v,
                                              input logic strobe);
        merge_byte = strobe ? new_v : old_v;
    endfunction

    function automatic logic is_lockable(input logic [7:0] idx);
        is_lockable = (idx >= `GCRB_IDX_GEN_CFG_A) && (idx <= `GCRB_IDX_WATCHDOG);
    endfunction

    function automatic logic [7:0] cfg_byte(input gcrb_pkg::gcrb_cfg_type c, input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        if (idx == `GCRB_IDX_GEN_CFG_A) begin
            v = c.gen_cfg_a;
        end else if (idx == `GCRB_IDX_SPV_IRQ_EN) begin
            v = c.spv_irq_en;
        end else if (idx == `GCRB_IDX_IRQ_MASK_HI) begin
            v = c.irq_mask[15:8];
        end else if (idx == `GCRB_IDX_IRQ_MASK_LO) begin
            v = c.irq_mask[7:0];
        end else if (idx == `GCRB_IDX_SEC_CH1_HI) begin
            v = c.sec_ch1[15:8];
        end else if (idx == `GCRB_IDX_SEC_CH1_LO) begin
            v = c.sec_ch1[7:0];
        end else if (idx == `GCRB_IDX_SEC_CH2_HI) begin
            v = c.sec_ch2[15:8];
        end else if (idx == `GCRB_IDX_SEC_CH2_LO) begin
            v = c.sec_ch2[7:0];
        end else if (idx == `GCRB_IDX_WATCHDOG) begin
            v = c.watchdog;
        end
        return v;
    endfunction

    function automatic gcrb_pkg::gcrb_cfg_type cfg_write(input gcrb_pkg::gcrb_cfg_type c,
                                                          input logic [7:0] idx,
                                                          input logic [7:0] d);
        gcrb_pkg::gcrb_cfg_type r;
        r = c;
        if (idx == `GCRB_IDX_GEN_CFG_A) begin
            r.gen_cfg_a = d;
        end else if (idx == `GCRB_IDX_SPV_IRQ_EN) begin
            r.spv_irq_en = d;
        end else if (idx == `GCRB_IDX_IRQ_MASK_HI) begin
            r.irq_mask[15:8] = d;
        end else if (idx == `GCRB_IDX_IRQ_MASK_LO) begin
            r.irq_mask[7:0] = d;
        end else if (idx == `GCRB_IDX_SEC_CH1_HI) begin
            r.sec_ch1[15:8] = d; // [R5]
        end else if (idx == `GCRB_IDX_SEC_CH1_LO) begin
            r.sec_ch1[7:0] = d; // [R5]
        end else if (idx == `GCRB_IDX_SEC_CH2_HI) begin
            r.sec_ch2[15:8] = d; // [R5]
        end else if (idx == `GCRB_IDX_SEC_CH2_LO) begin
            r.sec_ch2[7:0] = d; // [R5]
        end else if (idx == `GCRB_IDX_WATCHDOG) begin
            r.watchdog = d;
        end
        return r;
    endfunction

    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx >= `GCRB_IDX_GEN_CFG_A && idx <= `GCRB_IDX_DIE_IDX)
            || idx == `GCRB_IDX_SEC_STAT1 || idx == `GCRB_IDX_SEC_STAT2
            || idx == `GCRB_IDX_SPV_STAT || idx == `GCRB_IDX_IRQ_STAT
            || idx == `GCRB_IDX_BOOT_STAT;
    endfunction

    function automatic logic [7:0] read_byte(input gcrb_pkg::gcrb_state_type s,
                                             input logic [7:0] idx,
                                             input logic [7:0] dt, input logic [13:0] dr,
                                             input logic [7:0] st1, input logic [7:0] st2,
                                             input logic [7:0] spv, input logic [7:0] wdh,
                                             input logic [7:0] dil);
        logic [7:0] v;
        v = 8'h00; // [R7]
        if (idx <= `GCRB_IDX_WATCHDOG && idx >= `GCRB_IDX_GEN_CFG_A) begin
            v = cfg_byte(s.cfg, idx);
        end else if (idx == `GCRB_IDX_LOCK_RST) begin
            v = s.lock_reg;
        end else if (idx == `GCRB_IDX_CJ_TEMP_HI) begin
            v = s.cj_temp[15:8];
        end else if (idx == `GCRB_IDX_CJ_TEMP_LO) begin
            v = s.cj_temp[7:0];
        end else if (idx == `GCRB_IDX_DIE_TEMP) begin
            v = dt;
        end else if (idx == `GCRB_IDX_DIAG_SEL) begin
            v = s.diag_sel & `GCRB_DIAG_CH_MASK; // [R7]
        end else if (idx == `GCRB_IDX_DIAG_HI) begin
            v = dr[13:6];
        end else if (idx == `GCRB_IDX_DIAG_LO) begin
            v = {dr[5:0], 2'b00};
        end else if (idx == `GCRB_IDX_EE_STORE) begin
            v = s.ee_store;
        end else if (idx == `GCRB_IDX_TW_ADDR) begin
            v = s.tw_addr;
        end else if (idx == `GCRB_IDX_TW_PTR) begin
            v = s.tw_ptr;
        end else if (idx == `GCRB_IDX_TW_OP) begin
            v = s.tw_op;
        end else if (idx >= `GCRB_IDX_TW_B1 && idx <= `GCRB_IDX_TW_B4) begin
            v = s.tw_data[8 * (idx[1:0]) +: 8];
        end else if (idx == `GCRB_IDX_REV) begin
            v = `GCRB_ID_REV;
        end else if (idx == `GCRB_IDX_LOT) begin
            v = `GCRB_ID_LOT;
        end else if (idx == `GCRB_IDX_WAFER) begin
            v = wdh;
        end else if (idx == `GCRB_IDX_DIE_IDX) begin
            v = dil;
        end else if (idx == `GCRB_IDX_SEC_STAT1) begin
            v = st1 & `GCRB_STAT7_MASK; // [R5] [R7]
        end else if (idx == `GCRB_IDX_SEC_STAT2) begin
            v = st2 & `GCRB_STAT7_MASK; // [R5] [R7]
        end else if (idx == `GCRB_IDX_SPV_STAT) begin
            v = spv;
        end else if (idx == `GCRB_IDX_IRQ_STAT) begin
            v = s.irq_stat[7:0];
        end else if (idx == `GCRB_IDX_BOOT_STAT) begin
            v = {6'h00, s.crc_ok, s.boot == gcrb_pkg::GCRB_BOOT_DONE};
        end
        return v;
    endfunction

    logic [7:0] widx;
    logic [7:0] wbyte;
    logic [7:0] ridx;
    logic [15:0] irq_set;
    logic wr_fire;

    always_comb begin
        state_next = state_reg;
        irq_set = 16'h0000;
        widx = state_reg.aw_idx;
        wbyte = state_reg.wdata[7:0];
        wr_fire = 1'b0;
        ridx = s_axi_araddr[9:2];
        state_next.soft_reset = 1'b0;
        state_next.ee_req = 1'b0;

        // Start-up load from the EEPROM into a shadow copy
        case (state_reg.boot)
            gcrb_pkg::GCRB_BOOT_IDLE: begin
                state_next.ee_idx = `GCRB_EE_FIRST;
                state_next.boot = gcrb_pkg::GCRB_BOOT_REQ;
            end
            gcrb_pkg::GCRB_BOOT_REQ: begin
                state_next.ee_req = 1'b1; // [R1]
                state_next.ee_addr = state_reg.ee_idx;
                state_next.boot = gcrb_pkg::GCRB_BOOT_WAIT;
            end
            gcrb_pkg::GCRB_BOOT_WAIT: begin
                if (ee_ack) begin
                    state_next.shadow = cfg_write(state_reg.shadow, state_reg.ee_idx, ee_data);
                    if (state_reg.ee_idx == `GCRB_EE_LAST) begin
                        state_next.boot = gcrb_pkg::GCRB_BOOT_CHECK;
                    end else begin
                        state_next.ee_idx = state_reg.ee_idx + 8'h01;
                        state_next.boot = gcrb_pkg::GCRB_BOOT_REQ;
                    end
                end
            end
            gcrb_pkg::GCRB_BOOT_CHECK: begin
                state_next.crc_ok = ee_crc_valid;
                if (ee_crc_valid) begin
                    state_next.cfg = state_reg.shadow; // [R2]
                end else begin
                    irq_set[`GCRB_IRQ_CRC_ERR] = 1'b1;
                end
                irq_set[`GCRB_IRQ_BOOT_DONE] = 1'b1;
                state_next.boot = gcrb_pkg::GCRB_BOOT_DONE;
            end
            gcrb_pkg::GCRB_BOOT_DONE: begin
                state_next.boot = gcrb_pkg::GCRB_BOOT_DONE;
            end
            default: begin
                state_next.boot = gcrb_pkg::GCRB_BOOT_IDLE;
            end
        endcase

        // AXI write channel
        if (state_reg.axi.awready && s_axi_awvalid) begin
            state_next.aw_held = 1'b1;
            state_next.aw_idx = s_axi_awaddr[9:2];
            state_next.axi.awready = 1'b0;
            widx = s_axi_awaddr[9:2];
        end
        if (state_reg.axi.wready && s_axi_wvalid) begin
            state_next.w_held = 1'b1;
            state_next.wdata = s_axi_wdata;
            state_next.wstrb = s_axi_wstrb;
            state_next.axi.wready = 1'b0;
        end
        if (state_reg.aw_held && state_reg.w_held && !state_reg.axi.bvalid) begin
            wr_fire = state_reg.wstrb[0];
            state_next.axi.bvalid = 1'b1;
            state_next.axi.bresp = is_mapped(state_reg.aw_idx) ? `GCRB_RESP_OKAY
                                                                : `GCRB_RESP_SLVERR;
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
        end
        if (state_reg.axi.bvalid && s_axi_bready) begin
            state_next.axi.bvalid = 1'b0;
            state_next.axi.awready = 1'b1;
            state_next.axi.wready = 1'b1;
        end

        if (wr_fire) begin
            widx = state_reg.aw_idx;
            if (is_lockable(widx)) begin
                if (state_reg.locked) begin
                    irq_set[`GCRB_IRQ_LOCK_REFUSED] = 1'b1; // [R3]
                end else begin
                    state_next.cfg = cfg_write(state_next.cfg, widx, wbyte); // [R4]
                end
            end else if (widx == `GCRB_IDX_LOCK_RST) begin
                state_next.lock_reg = wbyte;
                state_next.locked = (wbyte == `GCRB_LOCK_CODE); // [R3]
                state_next.soft_reset = (wbyte == `GCRB_SOFT_RST_CODE);
            end else if (widx == `GCRB_IDX_CJ_TEMP_HI) begin
                state_next.cj_temp[15:8] = wbyte;
            end else if (widx == `GCRB_IDX_CJ_TEMP_LO) begin
                state_next.cj_temp[7:0] = wbyte;
            end else if (widx == `GCRB_IDX_DIAG_SEL) begin
                state_next.diag_sel = wbyte & `GCRB_DIAG_CH_MASK; // [R7]
            end else if (widx == `GCRB_IDX_EE_STORE) begin
                state_next.ee_store = wbyte;
            end else if (widx == `GCRB_IDX_TW_ADDR) begin
                state_next.tw_addr = wbyte;
            end else if (widx == `GCRB_IDX_TW_PTR) begin
                state_next.tw_ptr = wbyte;
            end else if (widx == `GCRB_IDX_TW_OP) begin
                state_next.tw_op = wbyte;
            end else if (widx >= `GCRB_IDX_TW_B1 && widx <= `GCRB_IDX_TW_B4) begin
                state_next.tw_data[8 * (widx[1:0]) +: 8] = wbyte;
            end else if (widx == `GCRB_IDX_IRQ_STAT) begin
                state_next.irq_stat[7:0] = state_reg.irq_stat[7:0] & ~wbyte;
            end
        end

        // Device-chosen contents override software values
        if (diag_auto_req) begin
            state_next.diag_sel = {1'b1, 3'b000, diag_auto_ch}; // [R6]
        end
        if (cj_temp_valid) begin
            state_next.cj_temp = cj_temp_meas; // [R6]
        end
        irq_set[`GCRB_IRQ_SPV] = |(spv_status & state_reg.cfg.spv_irq_en);

        // AXI read channel
        if (state_reg.axi.arready && s_axi_arvalid) begin
            state_next.axi.arready = 1'b0;
            state_next.axi.rvalid = 1'b1;
            state_next.axi.rdata = {24'h000000, read_byte(state_reg, ridx, die_temp, diag_result,
                                    sec_status_ch1, sec_status_ch2, spv_status,
                                    wafer_die_high, die_index_low)};
            state_next.axi.rresp = is_mapped(ridx) ? `GCRB_RESP_OKAY : `GCRB_RESP_SLVERR;
        end
        if (state_reg.axi.rvalid && s_axi_rready) begin
            state_next.axi.rvalid = 1'b0;
            state_next.axi.arready = 1'b1;
        end

        // Set wins over a clear in the same cycle
        state_next.irq_stat = state_next.irq_stat | irq_set;
        state_next.irq = |(state_next.irq_stat & state_next.cfg.irq_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || state_reg.soft_reset) begin
            state_reg <= '0;
            state_reg.boot <= gcrb_pkg::GCRB_BOOT_IDLE; // [R2]
            state_reg.cfg.watchdog <= `GCRB_RST_WATCHDOG;
            state_reg.axi.awready <= 1'b1;
            state_reg.axi.wready <= 1'b1;
            state_reg.axi.arready <= 1'b1;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    assign s_axi_awready = state_reg.axi.awready;
    assign s_axi_wready = state_reg.axi.wready;
    assign s_axi_bvalid = state_reg.axi.bvalid;
    assign s_axi_bresp = state_reg.axi.bresp;
    assign s_axi_arready = state_reg.axi.arready;
    assign s_axi_rvalid = state_reg.axi.rvalid;
    assign s_axi_rresp = state_reg.axi.rresp;
    assign s_axi_rdata = state_reg.axi.rdata;
    assign ee_req = state_reg.ee_req;
    assign ee_addr = state_reg.ee_addr;
    assign cfg_out = state_reg.cfg;
    assign locked = state_reg.locked;
    assign soft_reset = state_reg.soft_reset;
    assign boot_done = (state_reg.boot == gcrb_pkg::GCRB_BOOT_DONE);
    assign irq = state_reg.irq;

endmodule // gcrb_general_config_register_bank

// >>> include/gcrb_consts.svh
`ifndef GCRB_CONSTS_SVH
`define GCRB_CONSTS_SVH

// Register indices (byte address = index * 4)
`define GCRB_IDX_GEN_CFG_A 8'h30
`define GCRB_IDX_SPV_IRQ_EN 8'h31
`define GCRB_IDX_IRQ_MASK_HI 8'h32
`define GCRB_IDX_IRQ_MASK_LO 8'h33
`define GCRB_IDX_SEC_CH1_HI 8'h34
`define GCRB_IDX_SEC_CH1_LO 8'h35
`define GCRB_IDX_SEC_CH2_HI 8'h36
`define GCRB_IDX_SEC_CH2_LO 8'h37
`define GCRB_IDX_WATCHDOG 8'h38
`define GCRB_IDX_LOCK_RST 8'h39
`define GCRB_IDX_CJ_TEMP_HI 8'h3a
`define GCRB_IDX_CJ_TEMP_LO 8'h3b
`define GCRB_IDX_DIE_TEMP 8'h3c
`define GCRB_IDX_DIAG_SEL 8'h3d
`define GCRB_IDX_DIAG_HI 8'h3e
`define GCRB_IDX_DIAG_LO 8'h3f
`define GCRB_IDX_EE_STORE 8'h40
`define GCRB_IDX_TW_ADDR 8'h41
`define GCRB_IDX_TW_PTR 8'h42
`define GCRB_IDX_TW_OP 8'h43
`define GCRB_IDX_TW_B1 8'h44
`define GCRB_IDX_TW_B4 8'h47
`define GCRB_IDX_REV 8'h48
`define GCRB_IDX_LOT 8'h49
`define GCRB_IDX_WAFER 8'h4a
`define GCRB_IDX_DIE_IDX 8'h4b
`define GCRB_IDX_SEC_STAT1 8'h4e
`define GCRB_IDX_SEC_STAT2 8'h4f
`define GCRB_IDX_SPV_STAT 8'h52
// Own registers: interrupt status and start-up status
`define GCRB_IDX_IRQ_STAT 8'h60
`define GCRB_IDX_BOOT_STAT 8'h61

// Lock engages when this code is written to the lock register
`define GCRB_LOCK_CODE 8'h5a
// Soft reset when this code is written to the lock register
`define GCRB_SOFT_RST_CODE 8'ha5
// Automatic diagnostic enable bit in diagnostic_select
`define GCRB_DIAG_EN_BIT 7
`define GCRB_DIAG_CH_MASK 8'h8f
`define GCRB_STAT7_MASK 8'h7f

// Interrupt status bit positions
`define GCRB_IRQ_BOOT_DONE 0
`define GCRB_IRQ_CRC_ERR 1
`define GCRB_IRQ_LOCK_REFUSED 2
`define GCRB_IRQ_SPV 3

// EEPROM image: first and last loadable index
`define GCRB_EE_FIRST 8'h30
`define GCRB_EE_LAST 8'h38

// Reset defaults
`define GCRB_RST_ZERO 8'h00
`define GCRB_RST_WATCHDOG 8'h00

// Identity values: arbitrary
`define GCRB_ID_REV 8'h01
`define GCRB_ID_LOT 8'h00

// AXI responses
`define GCRB_RESP_OKAY 2'b00
`define GCRB_RESP_SLVERR 2'b10

`endif

// >>> include/gcrb_pkg.sv
package gcrb_pkg;

typedef enum {
    GCRB_BOOT_IDLE,
    GCRB_BOOT_REQ,
    GCRB_BOOT_WAIT,
    GCRB_BOOT_CHECK,
    GCRB_BOOT_DONE
} gcrb_boot_type;

typedef struct packed {
    logic [7:0] gen_cfg_a;
    logic [7:0] spv_irq_en;
    logic [15:0] irq_mask;
    logic [15:0] sec_ch1;
    logic [15:0] sec_ch2;
    logic [7:0] watchdog;
} gcrb_cfg_type;

typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
} gcrb_axi_out_type;

typedef struct packed {
    gcrb_cfg_type cfg;
    gcrb_cfg_type shadow;
    logic locked;
    logic [7:0] lock_reg;
    logic [15:0] cj_temp;
    logic [7:0] diag_sel;
    logic [7:0] ee_store;
    logic [7:0] tw_addr;
    logic [7:0] tw_ptr;
    logic [7:0] tw_op;
    logic [31:0] tw_data;
    logic [15:0] irq_stat;
    gcrb_boot_type boot;
    logic [7:0] ee_idx;
    logic crc_ok;
    logic aw_held;
    logic [7:0] aw_idx;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    gcrb_axi_out_type axi;
    logic ee_req;
    logic [7:0] ee_addr;
    logic soft_reset;
    logic irq;
} gcrb_state_type;

endpackage

// >>> verification/gcrb_props.sv
`timescale 1ns/1ps
`include "gcrb_consts.svh"
module gcrb_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ee_req,
    input wire logic [7:0] ee_addr,
    input gcrb_pkg::gcrb_cfg_type cfg_out,
    input wire logic locked,
    input wire logic boot_done
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn || !clk_en);
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wr_take(logic [7:0] i);
        wr_both ##0 s_axi_awaddr[9:2] == i;
    endsequence
    AST_B_LATENCY: assert property (wr_both |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_B_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    AST_EE_PULSE: assert property (ee_req |=> !ee_req)
        else $error("fetch request longer than one cycle");
    AST_EE_RANGE: assert property (ee_req |-> ee_addr >= `GCRB_EE_FIRST && ee_addr <= `GCRB_EE_LAST)
        else $error("fetch index outside loadable range");
    AST_LOCK_SET: assert property (wr_take(8'h39) ##0 s_axi_wdata[7:0] == `GCRB_LOCK_CODE
        |-> ##[1:3] locked)
        else $error("lock not engaged");
    AST_LOCK_REFUSE: assert property (wr_take(8'h30) ##0 locked |=> $stable(cfg_out.gen_cfg_a)[*3])
        else $error("locked register changed");
    AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == 8'h50
        |=> s_axi_rresp == `GCRB_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    AST_CH_INDEP: assert property (boot_done && $past(boot_done) && $changed(cfg_out.sec_ch1)
        |-> $stable(cfg_out.sec_ch2))
        else $error("channel two moved with channel one");
endmodule // gcrb_props
bind gcrb_general_config_register_bank gcrb_props chk_u (.*);

// >>> verification/gcrb_ee_model.sv
`timescale 1ns/1ps
module gcrb_ee_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ee_req,
    input wire logic [7:0] ee_addr,
    input wire logic crc_good,
    input wire logic slow,
    output logic ee_ack,
    output logic [7:0] ee_data,
    output logic ee_crc_valid
);
    logic busy;
    logic [1:0] wait_cnt;
    logic [7:0] addr;
    assign ee_crc_valid = crc_good;
    always_ff @(posedge aclk) begin
        ee_ack <= 1'b0;
        // Data is only meaningful beside the acknowledge
        ee_data <= ~ee_data;
        if (!aresetn) begin
            busy <= 1'b0;
            ee_data <= 8'h00;
        end else if (ee_req) begin
            busy <= 1'b1;
            wait_cnt <= slow ? 2'h3 : 2'h0;
            addr <= ee_addr;
        end else if (busy && wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
        end else if (busy) begin
            busy <= 1'b0;
            ee_ack <= 1'b1;
            ee_data <= addr ^ 8'h5c;
        end
    end
endmodule // gcrb_ee_model

// >>> verification/tb_general_config_register_bank.sv
`timescale 1ns/1ps
`include "gcrb_consts.svh"
module tb_general_config_register_bank;
    logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, crc_good = 1'b0, slow = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, diag_auto_req = 1'b0, cj_temp_valid = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h1, diag_auto_ch = 4'h0;
    logic [7:0] die_temp = 8'hc3, sec_status_ch1 = 8'hff, sec_status_ch2 = 8'h81;
    logic [7:0] spv_status = 8'h00, wafer_die_high = 8'h3c, die_index_low = 8'h96;
    logic [13:0] diag_result = 14'h2abc;
    logic [15:0] cj_temp_meas = 16'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic ee_req, ee_ack, ee_crc_valid, locked, soft_reset, boot_done, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] ee_addr, ee_data;
    gcrb_pkg::gcrb_cfg_type cfg_out;
    localparam logic [1:0] ok_resp = `GCRB_RESP_OKAY;
    localparam logic [1:0] err_resp = `GCRB_RESP_SLVERR;
    int mismatches = 0, compares = 0, cycles = 0;

    gcrb_general_config_register_bank dut_u (.*);
    gcrb_ee_model ee_u (.aclk(aclk), .aresetn(aresetn), .ee_req(ee_req), .ee_addr(ee_addr),
        .crc_good(crc_good), .slow(slow), .ee_ack(ee_ack), .ee_data(ee_data),
        .ee_crc_valid(ee_crc_valid));

    initial begin
        forever #10 aclk = ~aclk;
    end

    task automatic report_and_stop();
        if (mismatches == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end

    function automatic logic [7:0] img(input logic [7:0] i);
        return i ^ 8'h5c;
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= {22'h0, i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            aw = aw | (s_axi_awready === 1'b1);
            w = w | (s_axi_wready === 1'b1);
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        cmp({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er);
        s_axi_araddr <= {22'h0, i, 2'h0};
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        // Late ready keeps the read answer waiting for one cycle
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        cmp(s_axi_rdata, {24'h0, e});
        cmp({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic t_boot(input logic crc);
        @(posedge aclk);
        aresetn <= 1'b0;
        crc_good <= crc;
        slow <= !crc;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        do @(posedge aclk); while (boot_done !== 1'b1);
        @(posedge aclk);
        for (int i = 8'h30; i <= 8'h38; i++) begin
            rd(i[7:0], crc ? img(i[7:0]) : 8'h00, ok_resp);
        end
        rd(8'h61, {6'h0, crc, 1'b1}, ok_resp);
        rd(8'h60, {6'h0, !crc, 1'b1}, ok_resp);
        cmp({24'h0, cfg_out.watchdog}, {24'h0, crc ? img(8'h38) : 8'h00});
    endtask

    task automatic t_chan();
        wr(8'h34, 8'ha1, ok_resp);
        wr(8'h37, 8'h5e, ok_resp);
        rd(8'h36, img(8'h36), ok_resp);
        rd(8'h34, 8'ha1, ok_resp);
        cmp({16'h0, cfg_out.sec_ch1}, {16'h0, 8'ha1, img(8'h35)});
        cmp({16'h0, cfg_out.sec_ch2}, {16'h0, img(8'h36), 8'h5e});
    endtask

    task automatic t_lock();
        wr(8'h39, `GCRB_LOCK_CODE, ok_resp);
        cmp({31'h0, locked}, 32'h1);
        wr(8'h30, 8'hff, ok_resp);
        rd(8'h30, img(8'h30), ok_resp);
        rd(8'h60, 8'h05, ok_resp);
        wr(8'h60, 8'h05, ok_resp);
        rd(8'h60, 8'h00, ok_resp);
        wr(8'h39, 8'h00, ok_resp);
        cmp({31'h0, locked}, 32'h0);
        wr(8'h30, 8'hff, ok_resp);
        rd(8'h30, 8'hff, ok_resp);
    endtask

    task automatic t_irq();
        wr(8'h33, 8'h08, ok_resp);
        wr(8'h31, 8'h08, ok_resp);
        spv_status <= 8'h08;
        @(posedge aclk);
        spv_status <= 8'h00;
        repeat (2) @(posedge aclk);
        cmp({31'h0, irq}, 32'h1);
        wr(8'h33, 8'h00, ok_resp);
        cmp({31'h0, irq}, 32'h0);
        wr(8'h33, 8'h08, ok_resp);
        cmp({31'h0, irq}, 32'h1);
        wr(8'h60, 8'h08, ok_resp);
        rd(8'h60, 8'h00, ok_resp);
        cmp({31'h0, irq}, 32'h0);
    endtask

    task automatic t_auto();
        wr(8'h3d, 8'h03, ok_resp);
        rd(8'h3d, 8'h03, ok_resp);
        diag_auto_ch <= 4'h5;
        diag_auto_req <= 1'b1;
        @(posedge aclk);
        diag_auto_req <= 1'b0;
        cj_temp_meas <= 16'h1234;
        cj_temp_valid <= 1'b1;
        @(posedge aclk);
        cj_temp_valid <= 1'b0;
        @(posedge aclk);
        rd(8'h3d, 8'h85, ok_resp);
        rd(8'h3a, 8'h12, ok_resp);
        rd(8'h3b, 8'h34, ok_resp);
    endtask

    task automatic t_map();
        rd(8'h50, 8'h00, err_resp);
        wr(8'h50, 8'h11, err_resp);
        wr(8'h3d, 8'hff, ok_resp);
        rd(8'h3d, 8'h8f, ok_resp);
        rd(8'h3c, die_temp, ok_resp);
        rd(8'h3e, diag_result[13:6], ok_resp);
        rd(8'h3f, {diag_result[5:0], 2'h0}, ok_resp);
        rd(8'h4e, sec_status_ch1 & 8'h7f, ok_resp);
        rd(8'h4f, sec_status_ch2 & 8'h7f, ok_resp);
    endtask

    initial begin
        t_boot(1'b0);
        t_boot(1'b1);
        t_chan();
        t_lock();
        t_irq();
        t_auto();
        t_map();
        report_and_stop();
    end
endmodule // tb_general_config_register_bank
